/* File: core/uart_mp_pkg.sv */
// Constants and types for the multiprocessor serial port block.
// Assumes a 50 MHz clock and a classic Wishbone register bus.
package uart_mp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
    localparam logic [7:0] IDX_SLAVE_ID = 8'ha9;
    localparam logic [7:0] IDX_SLAVE_MASK = 8'hb9;
    localparam logic [7:0] IDX_POWER_CONTROL = 8'hc0;
    localparam logic [7:0] IDX_IRQ_ENABLE0 = 8'hc1;

    // Field positions in the control register
    localparam int SC_MODE0 = 7;
    localparam int SC_MODE1 = 6;
    localparam int SC_MPEN = 5;
    localparam int SC_RXALLOW = 4;
    localparam int SC_TB8 = 3;
    localparam int SC_RB8 = 2;
    localparam int SC_TI = 1;
    localparam int SC_RI = 0;
    // Field positions in power control and irq enable
    localparam int PC_FCS = 6;
    localparam int IE_GLOBAL = 7;
    localparam int IE_SERIAL = 4;

    // Values after reset
    localparam logic [7:0] SLAVE_ID_RST = 8'h00;
    localparam logic [7:0] SLAVE_MASK_RST = 8'h00;
    localparam logic [7:0] BUFFER_RST = 8'h00;
    localparam logic [10:0] TX_IDLE_RST = 11'h7ff;

    // Mode codes {mode bit0, mode bit1}
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_ASYNC8 = 2'h1;

    // Bit timing
    localparam int CLK_HZ = 50000000;
    localparam int BAUD_BPS = 115200;
    localparam int OVERSAMPLE = 16;
    localparam int BAUD_DIV = CLK_HZ / (BAUD_BPS * OVERSAMPLE);
    localparam logic [7:0] BAUD_DIV_LAST = 8'(BAUD_DIV - 1);
    localparam logic [3:0] PHASE_MID = 4'h7;
    localparam logic [3:0] PHASE_LAST = 4'hf;
    localparam logic [3:0] FRAME_BITS_8 = 4'ha;
    localparam logic [3:0] FRAME_BITS_9 = 4'hb;
    localparam logic [3:0] RX_NINTH_IDX = 4'h8;
    localparam logic [3:0] RX_STOP9_IDX = 4'h9;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA
    } rx_state_t;

endpackage : uart_mp_pkg

/* File: core/uart_mp_port.sv */
// Serial port with ninth-bit multiprocessor filtering and address match.
// Assumes a classic Wishbone master and an asynchronous rxd line.
//
// Notes on behaviour
// - Modes 2 and 3 with multiproc_enable filter frames by their ninth bit.
// - Filtering on: ninth bit zero frames dropped, no flag, no rx_ninth_bit.
// - Matching address frame sets rx_ninth_bit and receive-done, raising interrupt.
// - Address recognition on: receive-done only for frames matching this device.
// - Mode 1 filtering: stop bit marks address; needs match and valid stop.
// - Mode 0: multiproc_enable has no effect, no filtering or recognition.
// - Given match compares received address to slave_id only where mask is one.
// - Mask all ones matches only the exact slave_id value and, by broadcast, 8'hff.
// - Broadcast is id OR mask; its one bits must be received as one.
// - Address accepted on given or broadcast match.
// - Reset clears slave_id and slave_mask, so every address matches.
// - Receive-done OR transmit-done forms the interrupt; only software clears them.
// - Interrupt reaches core only with serial and global enables set.
// - With frame_check_select, bit 7 reads frame_stop_error; hardware sets, software clears.
// - Bits 7 and 6 hold the mode bits; bit 7 mode only without frame check.
// - Bit 4 rx_allow permits reception; zero keeps receiver idle.
// - Modes 2 and 3 send tx_ninth_bit as ninth bit; unused in modes 0, 1.
// - rx_ninth_bit takes stop bit in mode 1, ninth bit in modes 2 and 3.
// - Transmit-done set after last data bit shifted out, held until cleared.
// - Receive-done set at end of frame, at stop or ninth bit.
// - Modes 2 and 3 frame: start, eight data LSB first, ninth, stop.
// - Writing the buffer when idle and not in mode 0 starts sending with current mode and ninth bit.
// - Buffer reads give last received byte; writes give byte to send.
// - Frame check on: receive-done at stop bit; valid stops never clear error.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
module uart_mp_port
    import uart_mp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic irq_o
);

    typedef struct packed {
        logic [1:0] mode;
        logic mp_en;
        logic rx_allow;
        logic tb8;
        logic rb8;
        logic ti;
        logic ri;
        logic fe;
        logic fcs;
        logic es;
        logic ea;
        logic [7:0] rx_buf;
        logic [7:0] slave_id;
        logic [7:0] slave_mask;
        logic [7:0] div_cnt;
        logic tx_busy;
        logic [11:0] tx_shift;
        logic [3:0] tx_cnt;
        logic [3:0] tx_phase;
        rx_state_t rx_state;
        logic [3:0] rx_phase;
        logic [3:0] rx_idx;
        logic [7:0] rx_data;
        logic rx_ninth;
        logic rxd_m;
        logic rxd_s;
        logic rxd_p;
        logic ack;
        logic [7:0] dat;
    } state_t;

    state_t state_q;
    state_t state_d;

    // Given or broadcast address match
    function automatic logic addr_match(
        input logic [7:0] rx,
        input logic [7:0] id,
        input logic [7:0] mask
    );
        logic [7:0] bcast;
        logic given_hit;
        logic bcast_hit;
        bcast = id | mask;
        given_hit = (((rx ^ id) & mask) == 8'h00);
        bcast_hit = ((rx & bcast) == bcast);
        return given_hit | bcast_hit;
    endfunction : addr_match

    // Next state: bus, divider, transmitter and receiver
    always_comb begin
        logic tick;
        logic bus_wr;
        logic [7:0] idx;
        logic [7:0] wbyte;
        logic [7:0] rdata;
        logic mp_on;
        logic nine;
        logic bit_in;
        logic mark;
        logic [3:0] stop_idx;
        logic [3:0] dec_idx;
        logic tx_done_set;
        logic rx_done_set;
        logic fe_set;
        tick = 1'b0;
        bus_wr = 1'b0;
        idx = adr_i[9:2];
        wbyte = dat_i[7:0];
        rdata = 8'h00;
        mp_on = 1'b0;
        nine = 1'b0;
        bit_in = 1'b0;
        mark = 1'b0;
        stop_idx = RX_NINTH_IDX;
        dec_idx = RX_NINTH_IDX;
        tx_done_set = 1'b0;
        rx_done_set = 1'b0;
        fe_set = 1'b0;
        state_d = state_q;

        // Oversampling enable, one pulse per sixteenth of a bit
        tick = (state_q.div_cnt == BAUD_DIV_LAST);
        state_d.div_cnt = tick ? 8'h00 : state_q.div_cnt + 8'h01;

        // Two-stage synchroniser on the receive line
        state_d.rxd_m = rxd_i;
        state_d.rxd_s = state_q.rxd_m;
        // Previous synchronised level, for falling-edge start detection
        state_d.rxd_p = state_q.rxd_s;

        // Mode 0 shifter is absent, so filtering only in async modes
        mp_on = state_q.mp_en && (state_q.mode != MODE_SHIFT);
        nine = (state_q.mode != MODE_SHIFT) && (state_q.mode != MODE_ASYNC8);

        // Read mux, captured as the ack is raised
        unique case (idx)
            IDX_SERIAL_CONTROL: begin
                rdata[SC_MODE0] = state_q.fcs ? state_q.fe : state_q.mode[1];
                rdata[SC_MODE1] = state_q.mode[0];
                rdata[SC_MPEN] = state_q.mp_en;
                rdata[SC_RXALLOW] = state_q.rx_allow;
                rdata[SC_TB8] = state_q.tb8;
                rdata[SC_RB8] = state_q.rb8;
                rdata[SC_TI] = state_q.ti;
                rdata[SC_RI] = state_q.ri;
            end
            IDX_SERIAL_BUFFER: rdata = state_q.rx_buf;
            IDX_SLAVE_ID: rdata = state_q.slave_id;
            IDX_SLAVE_MASK: rdata = state_q.slave_mask;
            IDX_POWER_CONTROL: rdata[PC_FCS] = state_q.fcs;
            IDX_IRQ_ENABLE0: begin
                rdata[IE_GLOBAL] = state_q.ea;
                rdata[IE_SERIAL] = state_q.es;
            end
            default: rdata = 8'h00;
        endcase

        // Ack one cycle after the request; write lands on the ack edge
        state_d.ack = cyc_i && stb_i && !state_q.ack;
        state_d.dat = rdata;
        bus_wr = cyc_i && stb_i && we_i && state_q.ack && sel_i[0];

        // Software writes; hardware sets below take priority
        if (bus_wr) begin
            unique case (idx)
                IDX_SERIAL_CONTROL: begin
                    if (state_q.fcs) begin
                        state_d.fe = wbyte[SC_MODE0];
                    end else begin
                        state_d.mode[1] = wbyte[SC_MODE0];
                    end
                    state_d.mode[0] = wbyte[SC_MODE1];
                    state_d.mp_en = wbyte[SC_MPEN];
                    state_d.rx_allow = wbyte[SC_RXALLOW];
                    state_d.tb8 = wbyte[SC_TB8];
                    state_d.rb8 = wbyte[SC_RB8];
                    state_d.ti = wbyte[SC_TI];
                    state_d.ri = wbyte[SC_RI];
                end
                IDX_SERIAL_BUFFER: begin
                    // A write while a frame is going out is dropped
                    if (!state_q.tx_busy && state_q.mode != MODE_SHIFT) begin
                        state_d.tx_busy = 1'b1;
                        // Idle slot first, so the start bit begins on a tick
                        state_d.tx_phase = PHASE_LAST;
                        state_d.tx_cnt = nine ? FRAME_BITS_9 + 4'h1 : FRAME_BITS_8 + 4'h1;
                        // Mode 1 puts a stop bit in the ninth slot
                        state_d.tx_shift = {1'b1, nine ? state_q.tb8 : 1'b1,
                                            wbyte, 1'b0, 1'b1};
                    end
                end
                IDX_SLAVE_ID: state_d.slave_id = wbyte;
                IDX_SLAVE_MASK: state_d.slave_mask = wbyte;
                IDX_POWER_CONTROL: state_d.fcs = wbyte[PC_FCS];
                IDX_IRQ_ENABLE0: begin
                    state_d.ea = wbyte[IE_GLOBAL];
                    state_d.es = wbyte[IE_SERIAL];
                end
                default: state_d.dat = state_d.dat;
            endcase
        end

        // Transmit shifter, LSB first, one bit per sixteen ticks
        if (state_q.tx_busy && tick) begin
            state_d.tx_phase = state_q.tx_phase + 4'h1;
            if (state_q.tx_phase == PHASE_LAST) begin
                state_d.tx_shift = {1'b1, state_q.tx_shift[11:1]};
                state_d.tx_cnt = state_q.tx_cnt - 4'h1;
                // Stop bit now on the line: last data bit is out
                if (state_q.tx_cnt == 4'h2) begin
                    tx_done_set = 1'b1;
                end
                if (state_q.tx_cnt == 4'h1) begin
                    state_d.tx_busy = 1'b0;
                end
            end
        end

        // Receiver
        stop_idx = nine ? RX_STOP9_IDX : RX_NINTH_IDX;
        // Without frame check a nine-bit frame is decided at its ninth bit
        dec_idx = (nine && !state_q.fcs) ? RX_NINTH_IDX : stop_idx;
        bit_in = state_q.rxd_s;
        unique case (state_q.rx_state)
            RX_IDLE: begin
                // Falling edge of the line starts a frame
                // A low stop bit left on the line must not start a new frame
                if (state_q.rx_allow && state_q.mode != MODE_SHIFT && state_q.rxd_p &&
                        !state_q.rxd_s) begin
                    state_d.rx_state = RX_START;
                    state_d.rx_phase = 4'h0;
                end
            end
            RX_START: begin
                if (tick) begin
                    state_d.rx_phase = state_q.rx_phase + 4'h1;
                    if (state_q.rx_phase == PHASE_MID) begin
                        // A glitch shorter than half a bit is ignored
                        state_d.rx_state = bit_in ? RX_IDLE : RX_DATA;
                        state_d.rx_phase = 4'h0;
                        state_d.rx_idx = 4'h0;
                    end
                end
            end
            RX_DATA: begin
                if (tick) begin
                    state_d.rx_phase = state_q.rx_phase + 4'h1;
                    if (state_q.rx_phase == PHASE_LAST) begin
                        state_d.rx_idx = state_q.rx_idx + 4'h1;
                        if (state_q.rx_idx < RX_NINTH_IDX) begin
                            state_d.rx_data = {bit_in, state_q.rx_data[7:1]};
                        end
                        if (nine && state_q.rx_idx == RX_NINTH_IDX) begin
                            state_d.rx_ninth = bit_in;
                        end
                        // Marker: ninth bit in 9-bit modes, stop bit in mode 1
                        if (nine && state_q.rx_idx != RX_NINTH_IDX) begin
                            mark = state_q.rx_ninth;
                        end else begin
                            mark = bit_in;
                        end
                        if (state_q.rx_idx == dec_idx) begin
                            // Zero marker or foreign address is dropped silently
                            if (!mp_on || (mark && addr_match(state_q.rx_data,
                                    state_q.slave_id, state_q.slave_mask))) begin
                                state_d.rx_buf = state_q.rx_data;
                                state_d.rb8 = mark;
                                rx_done_set = 1'b1;
                            end
                        end
                        if (state_q.rx_idx == stop_idx) begin
                            fe_set = state_q.fcs && !bit_in;
                            state_d.rx_state = RX_IDLE;
                        end
                    end
                end
            end
            default: state_d.rx_state = RX_IDLE;
        endcase

        // Hardware sets win over a software clear in the same cycle
        if (tx_done_set) begin
            state_d.ti = 1'b1;
        end
        if (rx_done_set) begin
            state_d.ri = 1'b1;
        end
        if (fe_set) begin
            state_d.fe = 1'b1;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
            state_q.slave_id <= SLAVE_ID_RST;
            state_q.slave_mask <= SLAVE_MASK_RST;
            state_q.rx_buf <= BUFFER_RST;
            state_q.tx_shift <= {1'b1, TX_IDLE_RST};
            state_q.rx_state <= RX_IDLE;
            state_q.rxd_m <= 1'b1;
            state_q.rxd_s <= 1'b1;
            state_q.rxd_p <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs from the state register
    assign dat_o = {24'h000000, state_q.dat};
    assign ack_o = state_q.ack;
    assign txd_o = state_q.tx_shift[0];
    // Both done flags share one request, gated by two enables
    assign irq_o = (state_q.ri | state_q.ti) & state_q.es & state_q.ea;

endmodule : uart_mp_port

/* File: test/uart_mp_sva.sv */
// Port checks for the multiprocessor serial port.
// Assumes one clock and registers in byte lane 0 of the bus.
`timescale 1ns/100ps
module uart_mp_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic rxd_i,
    input wire logic txd_o,
    input wire logic irq_o
);
    localparam int BIT_CLKS = 432;
    int low_q;
    logic en_q;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Low run on txd; shadow of both irq enables, updated at the ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_q <= 0;
            en_q <= 1'h0;
        end else begin
            low_q <= txd_o ? 0 : low_q + 1;
            if (ack_o && we_i && sel_i[0] && adr_i[9:2] == 8'hc1)
                en_q <= dat_i[7] && dat_i[4];
        end
    end

    // Steps of a bus request and of a start bit
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence low_s;
        !txd_o [*8];
    endsequence

    AST_ACK_NEXT: assert property (req_s |=> ack_o)
        else $error("request not answered in one cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_RESET_IDLE: assert property ($fell(rst_i) |-> txd_o && !irq_o && !ack_o)
        else $error("outputs busy after reset");
    AST_DATA_UPPER: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bytes not zero");
    AST_UNMAPPED: assert property (ack_o && !we_i && adr_i[9:2] == 8'h00 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_START_WIDTH: assert property ($fell(txd_o) |-> low_s)
        else $error("short low bit on txd");
    AST_BIT_GRID: assert property ($rose(txd_o) |-> low_q % BIT_CLKS == 0 && low_q != 0)
        else $error("txd low run off the bit grid");
    AST_IRQ_GATED: assert property (!en_q |-> !irq_o)
        else $error("irq while disabled");
    AST_IRQ_SW_CLEAR: assert property ($fell(irq_o) |-> $past(ack_o && we_i) || $past(rst_i))
        else $error("irq dropped without a write");
endmodule : uart_mp_sva

bind uart_mp_port uart_mp_sva chk_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i,
    .sel_i, .cyc_i, .stb_i, .ack_o, .rxd_i, .txd_o, .irq_o);

/* File: test/uart_mp_far.sv */
// Far-side station: sends frames to rxd and captures frames from txd.
// Assumes 432 clocks a bit; the line idles high.
`timescale 1ns/100ps
module uart_mp_far (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    localparam int BIT_CLKS = 432;
    initial rxd_o = 1'h1;

    // Start, data lsb first, b9 as ninth or as stop, then stop
    task automatic send(input logic [7:0] d, input logic b9, input logic nine);
        logic [10:0] f;
        begin
            f = {1'h1, b9, d, 1'h0};
            for (int i = 0; i < (nine ? 11 : 10); i++) begin
                rxd_o <= f[i];
                repeat (BIT_CLKS) @(posedge clk_i);
            end
            rxd_o <= 1'h1;
        end
    endtask : send

    // Mid-bit sampling of an 11-bit frame; ok low if no start bit came
    task automatic grab(output logic [10:0] f, output logic ok);
        begin
            ok = 1'h0;
            for (int i = 0; i < 3000 && !ok; i++) begin
                @(posedge clk_i);
                ok = !txd_i;
            end
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            for (int i = 0; i < 11; i++) begin
                f[i] = txd_i;
                repeat (BIT_CLKS) @(posedge clk_i);
            end
        end
    endtask : grab
endmodule : uart_mp_far

/* File: test/uart_multiproc_address_match_bench.sv */
// Bench for the multiprocessor serial port: bus tasks and frame table.
// Assumes the far-side model on the line and the bound checker.
`timescale 1ns/100ps
module uart_multiproc_address_match_bench import uart_mp_pkg::*;;
    typedef struct packed {
        logic [7:0] ctl, id, mask, adr;
        logic b9, hit;
    } row_t;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [11:0] adr_i = 12'h0;
    logic [31:0] dat_i = 32'h0;
    logic we_i = 1'h0;
    logic [3:0] sel_i = 4'h0;
    logic cyc_i = 1'h0;
    logic stb_i = 1'h0;
    logic [31:0] dat_o;
    logic ack_o, rxd_i, txd_o, irq_o, ok;
    logic [7:0] rv;
    logic [10:0] fr;
    int err_count = 0;
    int checks_done = 0;
    row_t t;
    // Frame table: control, id, mask, address, ninth or stop, expected hit
    row_t tbl [11] = '{
        '{8'hf0, 8'h00, 8'h00, 8'h5a, 1'h1, 1'h1},
        '{8'hf0, 8'h00, 8'h00, 8'h33, 1'h0, 1'h0},
        '{8'hb0, 8'h56, 8'hfc, 8'h55, 1'h1, 1'h1},
        '{8'hf0, 8'h56, 8'hfc, 8'hfe, 1'h1, 1'h1},
        '{8'hf0, 8'h56, 8'hfc, 8'h5e, 1'h1, 1'h0},
        '{8'hf0, 8'h56, 8'hff, 8'h57, 1'h1, 1'h0},
        '{8'hf0, 8'h56, 8'hff, 8'h56, 1'h1, 1'h1},
        '{8'h70, 8'h56, 8'hff, 8'h56, 1'h1, 1'h1},
        '{8'h70, 8'h56, 8'hff, 8'h56, 1'h0, 1'h0},
        '{8'hd0, 8'h56, 8'hff, 8'h11, 1'h0, 1'h1},
        '{8'hc0, 8'h56, 8'hff, 8'h11, 1'h1, 1'h0}
    };

    always #10 clk_i = ~clk_i;

    uart_mp_port dut_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
        .stb_i, .ack_o, .rxd_i, .txd_o, .irq_o);
    uart_mp_far far_u (.clk_i, .txd_i(txd_o), .rxd_o(rxd_i));

    task automatic summarize();
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    task automatic bad(input string m);
        $display("unexpected at %0t: %s", $time, m);
        err_count++;
    endtask : bad

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
            bad($sformatf("got %h want %h", got, exp));
    endtask : cmp8

    // One classic cycle; held until ack is sampled, read data taken there
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        begin
            @(posedge clk_i);
            adr_i <= {2'h0, idx, 2'h0};
            dat_i <= {24'h0, d};
            we_i <= w;
            sel_i <= 4'h1;
            cyc_i <= 1'h1;
            stb_i <= 1'h1;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (ack_o !== 1'h1 && n < 20);
            rv = dat_o[7:0];
            cyc_i <= 1'h0;
            stb_i <= 1'h0;
            we_i <= 1'h0;
            if (n >= 20) begin
                bad("no ack");
                summarize();
            end
        end
    endtask : wb

    // One edge later so the combinational irq has settled
    task automatic irq_chk(input logic e);
        @(posedge clk_i);
        cmp8({7'h0, irq_o}, {7'h0, e});
    endtask : irq_chk

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, IDX_SLAVE_MASK, 8'h00);
        cmp8(rv, SLAVE_MASK_RST);
        wb(1'h0, 8'h00, 8'h00);
        cmp8(rv, 8'h00);
        wb(1'h1, IDX_IRQ_ENABLE0, 8'h90);
        foreach (tbl[i]) begin
            t = tbl[i];
            wb(1'h1, IDX_SLAVE_ID, t.id);
            wb(1'h1, IDX_SLAVE_MASK, t.mask);
            wb(1'h1, IDX_SERIAL_CONTROL, t.ctl);
            far_u.send(t.adr, t.b9, t.ctl[7]);
            wb(1'h0, IDX_SERIAL_CONTROL, 8'h00);
            cmp8(t.hit ? rv : rv & 8'hfb, t.hit ? t.ctl | {5'h0, t.b9, 2'h1} : t.ctl);
            irq_chk(t.hit);
            wb(1'h0, IDX_SERIAL_BUFFER, 8'h00);
            if (t.hit)
                cmp8(rv, t.adr);
        end
        // Error flag is sticky across a good frame
        wb(1'h1, IDX_SERIAL_CONTROL, 8'h50);
        wb(1'h1, IDX_POWER_CONTROL, 8'h40);
        far_u.send(8'h22, 1'h0, 1'h0);
        wb(1'h0, IDX_SERIAL_CONTROL, 8'h00);
        cmp8(rv, 8'hd1);
        far_u.send(8'h23, 1'h1, 1'h0);
        wb(1'h0, IDX_SERIAL_CONTROL, 8'h00);
        cmp8(rv, 8'hd5);
        wb(1'h1, IDX_IRQ_ENABLE0, 8'h80);
        irq_chk(1'h0);
        wb(1'h1, IDX_IRQ_ENABLE0, 8'h90);
        irq_chk(1'h1);
        // Mode 3 send with ninth bit set
        wb(1'h1, IDX_POWER_CONTROL, 8'h00);
        wb(1'h1, IDX_SERIAL_CONTROL, 8'hc8);
        irq_chk(1'h0);
        wb(1'h1, IDX_SERIAL_BUFFER, 8'ha5);
        far_u.grab(fr, ok);
        if (!ok)
            bad("no frame on txd");
        cmp8(fr[8:1], 8'ha5);
        cmp8({5'h0, fr[10:9], fr[0]}, 8'h06);
        wb(1'h0, IDX_SERIAL_CONTROL, 8'h00);
        cmp8(rv, 8'hca);
        summarize();
    end
endmodule : uart_multiproc_address_match_bench
